//--- logic/txn_unit.sv
// Transactional execution unit with lock elision and explicit regions
//
// Contract
// - Track read and write sets per line
// - Remote read of write-set, write of either conflicts
// - Abort discards updates, restores state, runs plainly
// - Updates become visible only at atomic commit
// - Elided acquire: lock in read set, no write
// - Free lock stays free to others
// - Own lock read returns acquired value
// - Matching elided release suppressed, then commit attempted
// - Failed hinted region reruns without elision
// - Without hint support, hints are ignored prefixes
// - Abort when tracking capacity is exceeded
// - Abort on unsafe instructions or system events
// - Status query and explicit abort provided
// - Suspend and resume load tracking
// - Explicit region abort restarts at fallback with status
// - Explicit abort immediate loaded into accumulator
// - Nested regions act as one outermost region
// - Hidden nesting count; enter at one, commit at zero
`timescale 1ns/10ps
`default_nettype none
module txn_unit
  import txn_pkg::*;
#(
  parameter int   ADDR_W       = ADDR_W_DEF,
  parameter int   DATA_W       = DATA_W_DEF,
  parameter int   LINE_OFS     = LINE_OFS_DEF,
  parameter int   TRK_ENTRIES  = TRK_ENTRIES_DEF,
  parameter int   SB_DEPTH     = SB_DEPTH_DEF,
  parameter int   MAX_NEST     = MAX_NEST_DEF,
  parameter logic HINT_SUPPORT = 1'b1
)
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // Core operation request
  input  wire logic              op_valid,
  output logic                   op_ready,
  input  wire logic [3:0]        op_code,
  input  wire logic [ADDR_W-1:0] op_addr,
  input  wire logic [DATA_W-1:0] op_wdata,
  input  wire logic [DATA_W-1:0] op_old_data,
  input  wire logic [7:0]        op_imm,
  input  wire logic [ADDR_W-1:0] op_fallback,
  // Load and status query answers
  output logic                   load_done,
  output logic                   load_fwd_hit,
  output logic [DATA_W-1:0]      load_data,
  output logic                   query_done,
  output logic                   query_txn,
  // Abort and restart
  output logic                   abort_pulse,
  output logic                   abort_acc_write,
  output logic [STATUS_W-1:0]    abort_status,
  output logic [ADDR_W-1:0]      restart_addr,
  output logic                   txn_active,
  output logic                   elision_off,
  // External writes to coherent memory
  output logic                   ext_wr_valid,
  output logic [ADDR_W-1:0]      ext_wr_addr,
  output logic [DATA_W-1:0]      ext_wr_data,
  output logic                   snoop_hold,
  // Remote snoops and system events
  input  wire logic              snoop_valid,
  input  wire logic              snoop_is_write,
  input  wire logic [ADDR_W-1:0] snoop_addr,
  input  wire logic              sys_event
);

  localparam int LINE_W = ADDR_W - LINE_OFS;
  localparam int TRK_IW = (TRK_ENTRIES > 1) ? $clog2(TRK_ENTRIES) : 1;
  localparam int SB_IW  = (SB_DEPTH > 1) ? $clog2(SB_DEPTH) : 1;
  localparam int SB_CW  = $clog2(SB_DEPTH + 1);
  localparam int NEST_W = $clog2(MAX_NEST + 1);

  txn_state_type      state_reg;
  txn_state_type      state_next;
  logic [NEST_W-1:0]  nest_reg;
  logic [NEST_W-1:0]  nest_next;
  logic               explicit_reg;
  logic               no_elide_reg;
  logic               suspend_reg;
  logic [ADDR_W-1:0]  fallback_reg;
  logic [LINE_W-1:0]  trk_line_reg [TRK_ENTRIES];
  logic [TRK_ENTRIES-1:0] trk_rd_reg;
  logic [TRK_ENTRIES-1:0] trk_wr_reg;
  logic [ADDR_W-1:0]  sb_addr_reg [SB_DEPTH];
  logic [DATA_W-1:0]  sb_data_reg [SB_DEPTH];
  logic [SB_CW-1:0]   sb_cnt_reg;
  logic [SB_CW-1:0]   sb_cnt_next;
  logic [SB_IW-1:0]   drain_idx_reg;
  logic               lock_vld_reg;
  logic [ADDR_W-1:0]  lock_addr_reg;
  logic [DATA_W-1:0]  lock_old_reg;
  logic [DATA_W-1:0]  lock_new_reg;

  // Associative lookups over the tracking marks and the store buffer
  function automatic logic [TRK_IW:0] trk_find(input logic [LINE_W-1:0] line);
    logic [TRK_IW:0] r;
    r = '0;
    for (int i = TRK_ENTRIES - 1; i >= 0; i--)
      if ((trk_rd_reg[i] | trk_wr_reg[i]) && trk_line_reg[i] == line)
        r = {1'b1, TRK_IW'(i)};
    return r;
  endfunction : trk_find

  function automatic logic [TRK_IW:0] trk_free();
    logic [TRK_IW:0] r;
    r = '0;
    for (int i = TRK_ENTRIES - 1; i >= 0; i--)
      if (!(trk_rd_reg[i] | trk_wr_reg[i]))
        r = {1'b1, TRK_IW'(i)};
    return r;
  endfunction : trk_free

  function automatic logic [SB_IW:0] sb_find(input logic [ADDR_W-1:0] addr);
    logic [SB_IW:0] r;
    r = '0;
    for (int i = SB_DEPTH - 1; i >= 0; i--)
      if (SB_CW'(i) < sb_cnt_reg && sb_addr_reg[i] == addr)
        r = {1'b1, SB_IW'(i)};
    return r;
  endfunction : sb_find

  // Operation decode
  wire is_idle   = (state_reg == ST_IDLE);
  wire is_txn    = (state_reg == ST_TXN);
  wire is_drain  = (state_reg == ST_DRAIN);
  wire take      = op_valid & op_ready;
  wire is_ld     = take & (op_code == OP_LOAD);
  wire is_st     = take & (op_code == OP_STORE);
  wire is_acq    = take & (op_code == OP_ACQUIRE);
  wire is_rel    = take & (op_code == OP_RELEASE);
  wire is_begin  = take & (op_code == OP_BEGIN);
  wire is_end    = take & (op_code == OP_END);
  wire is_txn_explicit_abort = take & (op_code == OP_ABORT);
  wire is_test   = take & (op_code == OP_TEST);
  wire is_susp   = take & (op_code == OP_SUSPEND);
  wire is_resume = take & (op_code == OP_RESUME);
  wire is_unsafe = take & (op_code == OP_UNSAFE);
  wire lock_hit  = lock_vld_reg & (op_addr == lock_addr_reg);
  wire [LINE_W-1:0] op_line    = op_addr[ADDR_W-1:LINE_OFS];
  wire [LINE_W-1:0] snoop_line = snoop_addr[ADDR_W-1:LINE_OFS];

  // hints act as plain writes when unsupported
  wire hint_on    = HINT_SUPPORT;
  // only one elided lock is tracked; later acquires are plain
  wire acq_elide  = is_acq & hint_on & ~no_elide_reg & ~lock_vld_reg & ~is_drain;
  wire acq_plain  = is_acq & ~acq_elide;
  // elide a release that restores the pre-acquire value
  wire rel_elide  = is_rel & hint_on & is_txn & lock_hit & (op_wdata == lock_old_reg);
  wire wr_path    = is_st | acq_plain | (is_rel & ~rel_elide);
  wire sb_store   = wr_path & is_txn;
  // plain stores go out only outside a region
  wire ext_direct = wr_path & is_idle;
  wire txn_start  = is_idle & (acq_elide | is_begin);

  // hinted ops and region begin/end move the hidden count
  wire nest_inc  = (hint_on & is_acq) | is_begin;
  wire nest_dec  = ((hint_on & is_rel) | (is_end & is_txn)) & (nest_reg != '0);
  wire nest_ovf  = is_txn & nest_inc & (nest_reg == NEST_W'(MAX_NEST));

  // read marks from loads and the elided lock, write marks from stores
  wire mark_rd   = (is_ld & is_txn & ~suspend_reg) | acq_elide;
  wire mark_wr   = sb_store;
  // Lookups read the marks directly, so they need a process, not a net
  logic [TRK_IW:0] trk_hit;
  logic [TRK_IW:0] trk_slot;
  logic [SB_IW:0]  sb_hit;
  always_comb
  begin
    trk_hit  = trk_find(op_line);
    trk_slot = trk_free();
    sb_hit   = sb_find(op_addr);
  end
  wire [TRK_IW-1:0] trk_idx = trk_hit[TRK_IW] ? trk_hit[TRK_IW-1:0] : trk_slot[TRK_IW-1:0];
  wire sb_full   = (sb_cnt_reg == SB_CW'(SB_DEPTH));
  // no free tracking slot or store buffer entry
  wire cap_fail  = ((mark_rd | mark_wr) & ~trk_hit[TRK_IW] & ~trk_slot[TRK_IW])
                 | (sb_store & ~sb_hit[SB_IW] & sb_full);

  // remote read hits a write mark, remote write hits any mark
  // snoop compared against every tracked line
  logic conflict;
  always_comb
  begin
    conflict = 1'b0;
    for (int i = 0; i < TRK_ENTRIES; i++)
      if (trk_line_reg[i] == snoop_line &&
          (trk_wr_reg[i] | (snoop_is_write & trk_rd_reg[i])))
        conflict = 1'b1;
  end
  wire snoop_conflict = snoop_valid & conflict;

  // unsafe instructions and system events abort
  // explicit abort only acts inside a region
  wire lock_bad  = is_txn & lock_hit & (is_st | is_acq | (is_rel & ~rel_elide));
  wire abort_go  = is_txn & (snoop_conflict | cap_fail | is_txn_explicit_abort | is_unsafe
                 | sys_event | lock_bad | nest_ovf);
  // commit only when the outermost level closes
  wire commit_go = is_txn & nest_dec & ~nest_inc & (nest_reg == NEST_W'(1)) & ~abort_go;
  wire drain_last = ({1'b0, drain_idx_reg} == SB_CW'(sb_cnt_reg - SB_CW'(1)));

  wire [STATUS_W-1:0] status_word =
      ({{(STATUS_W - ST_IMM_W){1'b0}}, (is_txn_explicit_abort ? op_imm : 8'h00)} << ST_IMM_LSB)
    | (STATUS_W'(is_txn_explicit_abort) << ST_EXPLICIT_BIT)
    | (STATUS_W'(snoop_conflict) << ST_RETRY_BIT)
    | (STATUS_W'(snoop_conflict) << ST_CONFLICT_BIT)
    | (STATUS_W'(cap_fail) << ST_CAPACITY_BIT)
    | (STATUS_W'(nest_reg > NEST_W'(1)) << ST_NESTED_BIT);

  // Drain blocks new ops so commit order stays intact
  assign op_ready   = ~is_drain;
  assign txn_active = is_txn;
  // remote agents are held off while the buffer drains
  assign snoop_hold = is_drain;
  assign elision_off = no_elide_reg;

  assign nest_next = abort_go ? '0 : NEST_W'(nest_reg + NEST_W'(nest_inc) - NEST_W'(nest_dec));
  assign sb_cnt_next = (sb_store & ~sb_hit[SB_IW] & ~sb_full) ? SB_CW'(sb_cnt_reg + SB_CW'(1))
                                                              : sb_cnt_reg;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (txn_start) state_next = ST_TXN;
      ST_TXN:
      begin
        if (abort_go)
          state_next = ST_IDLE;
        else if (commit_go)
          state_next = (sb_cnt_next != '0) ? ST_DRAIN : ST_IDLE;
      end
      ST_DRAIN: if (drain_last) state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_IDLE;
      nest_reg  <= '0;
    end
    else
    begin
      state_reg <= state_next;
      nest_reg  <= nest_next;
    end
  end

  // capture fallback target and region kind at outermost start
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fallback_reg <= '0;
      explicit_reg <= 1'b0;
    end
    else if (txn_start)
    begin
      fallback_reg <= op_fallback;
      explicit_reg <= is_begin;
    end
  end

  // after a hinted abort, rerun plainly until the count closes
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      no_elide_reg <= NO_ELIDE_RESET;
    else if (abort_go & ~explicit_reg)
      no_elide_reg <= 1'b1;
    else if (is_idle & nest_dec & (nest_reg == NEST_W'(1)))
      no_elide_reg <= 1'b0;
  end

  // suspend stops load read marking until resume or region end
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      suspend_reg <= 1'b0;
    else if (abort_go | commit_go | is_resume)
      suspend_reg <= 1'b0;
    else if (is_susp & is_txn)
      suspend_reg <= 1'b1;
  end

  // line marks, cleared whole at abort or commit
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      trk_rd_reg <= '0;
      trk_wr_reg <= '0;
    end
    else if (abort_go | commit_go)
    begin
      trk_rd_reg <= '0;
      trk_wr_reg <= '0;
    end
    else if ((mark_rd | mark_wr) & ~cap_fail)
    begin
      trk_rd_reg[trk_idx] <= trk_rd_reg[trk_idx] | mark_rd;
      trk_wr_reg[trk_idx] <= trk_wr_reg[trk_idx] | mark_wr;
    end
  end

  // Tag storage needs no reset; marks qualify it
  always_ff @(posedge core_clk)
  begin
    if ((mark_rd | mark_wr) & ~cap_fail & ~abort_go & ~trk_hit[TRK_IW])
      trk_line_reg[trk_idx] <= op_line;
  end

  // merge into a matching word or append
  always_ff @(posedge core_clk)
  begin
    if (sb_store & ~abort_go & (sb_hit[SB_IW] | ~sb_full))
    begin
      sb_addr_reg[sb_hit[SB_IW] ? sb_hit[SB_IW-1:0] : sb_cnt_reg[SB_IW-1:0]] <= op_addr;
      sb_data_reg[sb_hit[SB_IW] ? sb_hit[SB_IW-1:0] : sb_cnt_reg[SB_IW-1:0]] <= op_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sb_cnt_reg    <= '0;
      drain_idx_reg <= '0;
    end
    else if (abort_go | (is_drain & drain_last))
    begin
      sb_cnt_reg    <= '0;
      drain_idx_reg <= '0;
    end
    else
    begin
      sb_cnt_reg    <= sb_cnt_next;
      drain_idx_reg <= is_drain ? SB_IW'(drain_idx_reg + SB_IW'(1)) : '0;
    end
  end

  // elided lock remembered with the value the acquire would write
  // lock is never written externally while elided
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lock_vld_reg  <= 1'b0;
      lock_addr_reg <= '0;
      lock_old_reg  <= '0;
      lock_new_reg  <= '0;
    end
    else if (abort_go | commit_go | rel_elide)
      lock_vld_reg <= 1'b0;
    else if (acq_elide)
    begin
      lock_vld_reg  <= 1'b1;
      lock_addr_reg <= op_addr;
      lock_old_reg  <= op_old_data;
      lock_new_reg  <= op_wdata;
    end
  end

  // own lock read sees the acquired value
  wire fwd_lock = is_txn & lock_hit;
  wire fwd_sb   = is_txn & sb_hit[SB_IW];
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      load_done    <= 1'b0;
      load_fwd_hit <= 1'b0;
      load_data    <= '0;
    end
    else
    begin
      load_done    <= is_ld;
      load_fwd_hit <= is_ld & (fwd_lock | fwd_sb);
      load_data    <= fwd_lock ? lock_new_reg
                    : fwd_sb   ? sb_data_reg[sb_hit[SB_IW-1:0]] : '0;
    end
  end

  // status query answers one cycle later
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      query_done <= 1'b0;
      query_txn  <= 1'b0;
    end
    else
    begin
      query_done <= is_test;
      query_txn  <= is_test & is_txn;
    end
  end

  // restart at fallback; immediate into accumulator
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      abort_pulse     <= 1'b0;
      abort_acc_write <= 1'b0;
      abort_status    <= STATUS_RESET;
      restart_addr    <= '0;
    end
    else
    begin
      abort_pulse     <= abort_go;
      abort_acc_write <= abort_go & explicit_reg;
      if (abort_go)
      begin
        abort_status <= status_word;
        restart_addr <= fallback_reg;
      end
    end
  end

  // buffered stores leave one per cycle, one cycle behind the drain slot; the last leaves after the snoop hold drops
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ext_wr_valid <= 1'b0;
      ext_wr_addr  <= '0;
      ext_wr_data  <= '0;
    end
    else
    begin
      ext_wr_valid <= ext_direct | is_drain;
      ext_wr_addr  <= is_drain ? sb_addr_reg[drain_idx_reg] : op_addr;
      ext_wr_data  <= is_drain ? sb_data_reg[drain_idx_reg] : op_wdata;
    end
  end

endmodule : txn_unit
`default_nettype wire

//--- common/txn_pkg.sv
// Constants and types shared by the transactional execution unit
`default_nettype none
package txn_pkg;

  // Core operation codes
  localparam logic [3:0] OP_LOAD    = 4'h0;
  localparam logic [3:0] OP_STORE   = 4'h1;
  localparam logic [3:0] OP_ACQUIRE = 4'h2;
  localparam logic [3:0] OP_RELEASE = 4'h3;
  localparam logic [3:0] OP_BEGIN   = 4'h4;
  localparam logic [3:0] OP_END     = 4'h5;
  localparam logic [3:0] OP_ABORT   = 4'h6;
  localparam logic [3:0] OP_TEST    = 4'h7;
  localparam logic [3:0] OP_SUSPEND = 4'h8;
  localparam logic [3:0] OP_RESUME  = 4'h9;
  localparam logic [3:0] OP_UNSAFE  = 4'hA;

  // Abort status word field positions
  localparam int ST_EXPLICIT_BIT = 0;
  localparam int ST_RETRY_BIT    = 1;
  localparam int ST_CONFLICT_BIT = 2;
  localparam int ST_CAPACITY_BIT = 3;
  localparam int ST_NESTED_BIT   = 5;
  localparam int ST_IMM_LSB      = 24;
  localparam int ST_IMM_W        = 8;
  localparam int STATUS_W        = 32;

  // Reset values
  localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;
  localparam logic        NO_ELIDE_RESET = 1'b0;

  // Geometry defaults
  localparam int ADDR_W_DEF      = 32;
  localparam int DATA_W_DEF      = 32;
  localparam int LINE_OFS_DEF    = 6;
  localparam int WORD_OFS_DEF    = 2;
  localparam int TRK_ENTRIES_DEF = 16;
  localparam int SB_DEPTH_DEF    = 8;
  localparam int MAX_NEST_DEF    = 7;

  // Top-level sequencing states
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_TXN   = 3'b010,
    ST_DRAIN = 3'b100
  } txn_state_type;

endpackage : txn_pkg
`default_nettype wire

//--- dv/txn_unit_checker.sv
// Port-level checks for the transactional unit
`timescale 1ns/10ps
`default_nettype none
module txn_unit_checker
  import txn_pkg::*;
(
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                reset_n,
  // Core side
  input wire logic                op_valid,
  input wire logic                op_ready,
  input wire logic [3:0]          op_code,
  input wire logic [7:0]          op_imm,
  input wire logic                load_done,
  input wire logic                query_done,
  input wire logic                query_txn,
  // Abort and state
  input wire logic                abort_pulse,
  input wire logic [STATUS_W-1:0] abort_status,
  input wire logic                txn_active,
  input wire logic                elision_off,
  // Memory side
  input wire logic                ext_wr_valid,
  input wire logic                snoop_hold,
  input wire logic                sys_event
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  wire logic take = op_valid && op_ready;

  a_load_answer: assert property (take && op_code == OP_LOAD |=> load_done)
    else $error("load answer missing");
  a_query_state: assert property (take && op_code == OP_TEST |=>
    query_done && query_txn == $past(txn_active)) else $error("status query wrong");
  a_acquire_elides: assert property (take && op_code == OP_ACQUIRE &&
    !txn_active && !elision_off |=> txn_active && !ext_wr_valid)
    else $error("elided acquire wrong");
  a_no_early_write: assert property (txn_active && $past(txn_active) |->
    !ext_wr_valid) else $error("write seen inside region");
  a_event_abort: assert property (sys_event && txn_active |=>
    abort_pulse && !txn_active) else $error("system event did not abort");
  a_explicit_imm: assert property (take && op_code == OP_ABORT && txn_active |=>
    abort_pulse && abort_status[ST_EXPLICIT_BIT] &&
    abort_status[ST_IMM_LSB +: ST_IMM_W] == $past(op_imm)) else $error("abort code wrong");
  a_status_holds: assert property (!abort_pulse |-> $stable(abort_status))
    else $error("status changed without abort");
  a_abort_shape: assert property (abort_pulse |-> !txn_active ##1 !abort_pulse)
    else $error("abort pulse shape wrong");
  a_drain_bounded: assert property ($rose(snoop_hold) |-> ##[1:12] !snoop_hold)
    else $error("commit drain too long");
endmodule : txn_unit_checker

bind txn_unit txn_unit_checker u_txn_unit_checker (.core_clk, .reset_n, .op_valid,
  .op_ready, .op_code, .op_imm, .load_done, .query_done, .query_txn, .abort_pulse,
  .abort_status, .txn_active, .elision_off, .ext_wr_valid, .snoop_hold, .sys_event);
`default_nettype wire

//--- dv/remote_agent.sv
// Model of another processor sharing coherent memory
`timescale 1ns/10ps
`default_nettype none
module remote_agent
(
  // Clock
  input  wire logic        core_clk,
  // Unit's memory side
  input  wire logic        snoop_hold,
  input  wire logic        ext_wr_valid,
  input  wire logic [31:0] ext_wr_addr,
  input  wire logic [31:0] ext_wr_data,
  output var  logic        snoop_valid,
  output var  logic        snoop_is_write,
  output var  logic [31:0] snoop_addr
);
  logic [31:0] mem [logic [31:0]];
  initial
  begin
    snoop_valid = 1'b0;
    snoop_is_write = 1'b0;
    snoop_addr = 32'h0000_0000;
  end
  always @(posedge core_clk)
    if (ext_wr_valid === 1'b1)
      mem[ext_wr_addr] = ext_wr_data;
  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 32'h0000_0000;
  endfunction : peek
  task automatic access(input logic wr, input logic [31:0] a);
    @(negedge core_clk);
    while (snoop_hold !== 1'b0)
      @(negedge core_clk);
    snoop_valid = 1'b1;
    snoop_is_write = wr;
    snoop_addr = a;
    @(negedge core_clk);
    snoop_valid = 1'b0;
    snoop_is_write = ~wr;
    snoop_addr = ~a;
  endtask : access
endmodule : remote_agent
`default_nettype wire

//--- dv/transactional_lock_elision_tb_top.sv
// Self-checking bench for the transactional unit
`timescale 1ns/10ps
`default_nettype none
module transactional_lock_elision_tb_top;
  import txn_pkg::*;
  localparam int CAP = 4;
  localparam logic [31:0] LK_A = 32'h0000_1000;
  localparam logic [31:0] LK_B = 32'h0000_1400;
  localparam logic [31:0] FB_O = 32'h0000_8000;
  localparam logic [31:0] FB_I = 32'h0000_9000;
  logic        core_clk, reset_n, op_valid, sys_event;
  logic [3:0]  op_code;
  logic [31:0] op_addr, op_wdata, op_fallback, d;
  logic [7:0]  op_imm;
  wire logic   op_ready, load_done, load_fwd_hit, query_done, query_txn, abort_pulse;
  wire logic   abort_acc_write, txn_active, elision_off, ext_wr_valid, snoop_hold;
  wire logic   snoop_valid, snoop_is_write;
  wire logic [31:0] load_data, abort_status, restart_addr, ext_wr_addr, ext_wr_data;
  wire logic [31:0] snoop_addr;
  logic [63:0] exp_q [$];
  int          bad_count, n_compared, cycles, i, k;
  int          seed = 74;

  txn_unit #(.TRK_ENTRIES(CAP), .SB_DEPTH(CAP)) u_txn_unit (.core_clk, .reset_n,
    .op_valid, .op_ready, .op_code, .op_addr, .op_wdata, .op_old_data(32'h0000_0000),
    .op_imm, .op_fallback, .load_done, .load_fwd_hit, .load_data, .query_done,
    .query_txn, .abort_pulse, .abort_acc_write, .abort_status, .restart_addr,
    .txn_active, .elision_off, .ext_wr_valid, .ext_wr_addr, .ext_wr_data, .snoop_hold,
    .snoop_valid, .snoop_is_write, .snoop_addr, .sys_event);
  remote_agent u_remote_agent (.core_clk, .snoop_hold, .ext_wr_valid, .ext_wr_addr,
    .ext_wr_data, .snoop_valid, .snoop_is_write, .snoop_addr);

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One op per call, dropped after the taking edge
  task automatic op(input logic [3:0] c, input logic [31:0] a, input logic [31:0] w,
                    input logic [7:0] m, input logic [31:0] f);
    @(negedge core_clk);
    while (op_ready !== 1'b1)
      @(negedge core_clk);
    op_valid = 1'b1;
    op_code = c;
    op_addr = a;
    op_wdata = w;
    op_imm = m;
    op_fallback = f;
    @(negedge core_clk);
    op_valid = 1'b0;
  endtask : op

  task automatic wait_idle;
    @(negedge core_clk);
    for (int n = 0; n < 20 && snoop_hold !== 1'b0; n++)
      @(negedge core_clk);
    // Last drained write reaches the model one edge later
    @(negedge core_clk);
  endtask : wait_idle

  task automatic do_reset;
    @(negedge core_clk);
    reset_n = 1'b0;
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    chk({op_ready, txn_active, abort_status}, {2'b10, STATUS_RESET});
  endtask : do_reset

  // External writes must match the expected queue, in order
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      bad_count++;
      stop_test();
    end
    else if (reset_n === 1'b1 && ext_wr_valid === 1'b1)
      chk({ext_wr_addr, ext_wr_data}, exp_q.size() > 0 ? exp_q.pop_front() :
          ~{ext_wr_addr, ext_wr_data});
  end

  initial
  begin
    {reset_n, op_valid, sys_event, op_code, op_addr, op_wdata, op_imm, op_fallback} = '0;
    do_reset();
    // Elided lock walk
    op(OP_ACQUIRE, LK_A, 32'h1, 8'h0, FB_O);
    chk({txn_active, u_remote_agent.peek(LK_A)}, 33'h1_0000_0000);
    op(OP_LOAD, LK_A, 32'h0, 8'h0, FB_O);
    chk({load_done, load_fwd_hit, load_data}, {2'b11, 32'h1});
    d = $random(seed);
    op(OP_STORE, 32'h0000_2000, d, 8'h0, FB_O);
    exp_q.push_back({32'h0000_2000, d});
    u_remote_agent.access(1'b0, LK_A);
    chk({abort_pulse, u_remote_agent.peek(32'h0000_2000)}, 33'h0);
    op(OP_RELEASE, LK_A, 32'h0, 8'h0, FB_O);
    wait_idle();
    chk({txn_active, (exp_q.size() != 0), u_remote_agent.peek(LK_A)}, 64'h0);
    chk(u_remote_agent.peek(32'h0000_2000), d);
    // Conflict on the elided lock, then plain rerun
    op(OP_ACQUIRE, LK_A, 32'h1, 8'h0, FB_O);
    op(OP_STORE, 32'h0000_2400, $random(seed), 8'h0, FB_O);
    u_remote_agent.access(1'b1, LK_A + 32'h4);
    chk({abort_pulse, abort_acc_write, abort_status[ST_CONFLICT_BIT], elision_off,
         txn_active}, 5'b10110);
    chk(restart_addr, FB_O);
    // fallback path takes the lock for real
    exp_q.push_back({LK_A, 32'h1});
    exp_q.push_back({LK_A, 32'h0});
    op(OP_ACQUIRE, LK_A, 32'h1, 8'h0, FB_O);
    op(OP_RELEASE, LK_A, 32'h0, 8'h0, FB_O);
    repeat (3) @(negedge core_clk);
    chk({exp_q.size(), txn_active, elision_off}, 34'h0);
    chk(u_remote_agent.peek(32'h0000_2400), 32'h0);
    // Read-set versus write-set remote reads
    op(OP_BEGIN, 32'h0, 32'h0, 8'h0, FB_O);
    op(OP_LOAD, 32'h0000_3000, 32'h0, 8'h0, FB_O);
    op(OP_STORE, 32'h0000_3400, $random(seed), 8'h0, FB_O);
    u_remote_agent.access(1'b0, 32'h0000_3000);
    chk({abort_pulse, txn_active}, 2'b01);
    u_remote_agent.access(1'b0, 32'h0000_3420);
    chk({abort_pulse, abort_acc_write, abort_status[ST_CONFLICT_BIT]}, 3'b111);
    chk(restart_addr, FB_O);
    // Nested explicit regions and the status query
    op(OP_TEST, 32'h0, 32'h0, 8'h0, FB_O);
    chk({query_done, query_txn}, 2'b10);
    op(OP_BEGIN, 32'h0, 32'h0, 8'h0, FB_O);
    op(OP_BEGIN, 32'h0, 32'h0, 8'h0, FB_I);
    op(OP_TEST, 32'h0, 32'h0, 8'h0, FB_O);
    chk({query_done, query_txn}, 2'b11);
    d = $random(seed);
    op(OP_ABORT, 32'h0, 32'h0, d[7:0], FB_O);
    chk({abort_pulse, abort_acc_write, abort_status[ST_EXPLICIT_BIT],
         abort_status[ST_IMM_LSB +: ST_IMM_W]}, {3'b111, d[7:0]});
    chk(restart_addr, FB_O);
    op(OP_ABORT, 32'h0, 32'h0, 8'h5A, FB_O);
    chk(abort_pulse, 1'b0);
    do_reset();
    // Unsafe op and system event both abort
    for (k = 0; k < 2; k++)
    begin
      op(OP_BEGIN, 32'h0, 32'h0, 8'h0, FB_O);
      if (k == 0)
        op(OP_UNSAFE, 32'h0, 32'h0, 8'h0, FB_O);
      else
      begin
        @(negedge core_clk);
        sys_event = 1'b1;
        @(negedge core_clk);
        sys_event = 1'b0;
      end
      chk({abort_pulse, txn_active}, 2'b10);
    end
    // Suspended load tracking
    op(OP_BEGIN, 32'h0, 32'h0, 8'h0, FB_O);
    op(OP_SUSPEND, 32'h0, 32'h0, 8'h0, FB_O);
    op(OP_LOAD, 32'h0000_5000, 32'h0, 8'h0, FB_O);
    op(OP_RESUME, 32'h0, 32'h0, 8'h0, FB_O);
    u_remote_agent.access(1'b1, 32'h0000_5000);
    chk({abort_pulse, txn_active}, 2'b01);
    d = $random(seed);
    exp_q.push_back({32'h0000_5400, d});
    op(OP_STORE, 32'h0000_5400, d, 8'h0, FB_O);
    op(OP_END, 32'h0, 32'h0, 8'h0, FB_O);
    wait_idle();
    chk({txn_active, exp_q.size()}, 33'h0);
    // Capacity overflow on distinct lines
    op(OP_BEGIN, 32'h0, 32'h0, 8'h0, FB_O);
    for (i = 0; i <= CAP && txn_active === 1'b1; i++)
      op(OP_STORE, 32'h0001_0000 + i * 64, $random(seed), 8'h0, FB_O);
    chk({abort_status[ST_CAPACITY_BIT], txn_active, exp_q.size()}, 34'h2_0000_0000);
    // Hidden nesting count over two locks
    op(OP_ACQUIRE, LK_A, 32'h1, 8'h0, FB_O);
    op(OP_ACQUIRE, LK_B, 32'h1, 8'h0, FB_O);
    op(OP_RELEASE, LK_B, 32'h0, 8'h0, FB_O);
    chk(txn_active, 1'b1);
    exp_q.push_back({LK_B, 32'h0});
    op(OP_RELEASE, LK_A, 32'h0, 8'h0, FB_O);
    wait_idle();
    chk({txn_active, exp_q.size()}, 33'h0);
    stop_test();
  end
endmodule : transactional_lock_elision_tb_top
`default_nettype wire
